// ---- rtl/slc_pkg.sv ----
// Summary of operation
// - Control field bit 7 set; type in 7..6 for information, 7..5 otherwise
// - Supervisory kinds: ready, reject, not-ready, selective
// - Unnumbered codes: reset 11001, acknowledge 00110
// - Supervisory frames never carry payload
// - One selective reject outstanding per direction
// - Selective reject only when negotiated
// - Window defaults to four, reducible at setup
// - Reset payload: window 2..4, then capability byte
// - Offered window too large: answer own reset
// - Smaller requested window adopted, acknowledge sent
// - Unsupported capabilities: reset with supported ones
// - Response reset equal to received becomes acknowledge
// - Capability bit 0 is selective reject support
// - Negotiated window holds until next establishment
// - Acknowledge within 5 ms times window over four
// - Retransmit unacknowledged after at least 10 ms
// - No answer within 5 ms: retry reset
// - Send counter modulo 8, increments per emission
// - Receive counter acknowledges all below it
// - Oldest-unacked to send counter awaits acknowledge
// - Modulo-8 window membership comparison
// - Counters cleared to zero on establishment
// - Setup starts with reset, done on acknowledge
// - Before setup only peer resets accepted
package slc_pkg;
   localparam logic [1:0] SLC_TY_I0 = 2'h2;
   localparam logic [2:0] SLC_TY_S = 3'h6;
   localparam logic [2:0] SLC_TY_U = 3'h7;
   localparam logic [1:0] SLC_S_RR = 2'h0;
   localparam logic [1:0] SLC_S_REJ = 2'h1;
   localparam logic [1:0] SLC_S_RNR = 2'h2;
   localparam logic [1:0] SLC_S_SELECTIVE_REJECT_FRAME = 2'h3;
   localparam logic [4:0] SLC_U_RESET = 5'h19;
   localparam logic [4:0] SLC_U_ACK = 5'h06;
   localparam logic [2:0] SLC_WIN_DEF = 3'h4;
   localparam logic [2:0] SLC_WIN_MIN = 3'h2;
   localparam int SLC_CAP_SELECTIVE_REJECT_FRAME_BIT = 0;
   localparam int SLC_CLK_KHZ = 100000;
   localparam int SLC_ACK_US = 5000;
   localparam int SLC_RETX_US = 10000;
   localparam int SLC_CONN_US = 5000;
   // Longest times round down, least times round up
   localparam int SLC_ACK_CYC = SLC_ACK_US * (SLC_CLK_KHZ / 1000);
   localparam int SLC_RETX_CYC = (SLC_RETX_US * SLC_CLK_KHZ + 999) / 1000;
   localparam int SLC_CONN_CYC = SLC_CONN_US * (SLC_CLK_KHZ / 1000);
endpackage

// ---- rtl/slc_timer.sv ----
`timescale 1ns/1ps
module slc_timer #(
   parameter int LIMIT = 1000
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic stop,
   input wire logic [31:0] limit,
   output logic expired
);
   logic [31:0] cnt_q;
   logic run_q;
   always_ff @(posedge core_clk) begin
      if (!rst_n || stop) begin
         run_q <= 1'b0;
         cnt_q <= 32'h0;
      end else if (start) begin
         run_q <= 1'b1;
         cnt_q <= 32'h0;
      end else if (run_q) begin
         if (cnt_q + 32'h1 >= limit) begin
            run_q <= 1'b0;
         end
         cnt_q <= cnt_q + 32'h1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         expired <= 1'b0;
      end else begin
         expired <= run_q && !start && !stop && (cnt_q + 32'h1 >= limit);
      end
   end
endmodule

// ---- rtl/slc_ctrl.sv ----
`timescale 1ns/1ps
module slc_ctrl #(
   parameter int ACK_CYC = slc_pkg::SLC_ACK_CYC,
   parameter int RETX_CYC = slc_pkg::SLC_RETX_CYC,
   parameter int CONN_CYC = slc_pkg::SLC_CONN_CYC,
   parameter logic [2:0] LOCAL_WIN = slc_pkg::SLC_WIN_DEF,
   parameter logic LOCAL_SELECTIVE_REJECT_FRAME = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic link_start,
   // Received frame, already delimited and checked
   input wire logic rx_valid,
   input wire logic [7:0] rx_ctrl,
   input wire logic [1:0] rx_plen,
   input wire logic [7:0] rx_win,
   input wire logic [7:0] rx_cap,
   input wire logic rx_has_info,
   // Upper layer offers an information frame
   input wire logic info_req,
   output logic info_gnt,
   input wire logic local_busy,
   // Frame to transmit, held until tx_ready
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_ctrl,
   output logic [1:0] tx_plen,
   output logic [7:0] tx_win,
   output logic [7:0] tx_cap,
   output logic tx_retx,
   output logic [2:0] tx_retx_seq,
   output logic rx_deliver,
   output logic link_up,
   output logic [2:0] win_size,
   output logic selective_reject_frame_en,
   output logic [2:0] send_seq,
   output logic [2:0] recv_seq,
   output logic [2:0] oldest_unacked_seq,
   output logic link_reset_evt
);
   typedef enum logic [1:0] {SLC_DOWN, SLC_WAIT, SLC_UP} slc_state_t;

   // ======================================
   // Helpers
   // ======================================
   function automatic logic in_win(input logic [2:0] x, input logic [2:0] y,
                                   input logic [2:0] z);
      if (x <= z) begin
         in_win = (x <= y) && (y < z);
      end else begin
         in_win = (y >= x) || (y < z);
      end
   endfunction

   function automatic logic [7:0] mk_u(input logic [4:0] m);
      mk_u = {slc_pkg::SLC_TY_U, m};
   endfunction

   function automatic logic [7:0] mk_s(input logic [1:0] k, input logic [2:0] nr);
      mk_s = {slc_pkg::SLC_TY_S, k, nr};
   endfunction

   // ======================================
   // Receive decode
   // ======================================
   logic is_i, is_s, is_u, is_reset, is_ack;
   logic [2:0] r_ns, r_nr;
   logic [1:0] r_kind;
   logic [2:0] off_win;
   logic off_selective_reject_frame;
   assign is_i = rx_valid && rx_ctrl[7:6] == slc_pkg::SLC_TY_I0;
   assign is_s = rx_valid && rx_ctrl[7:5] == slc_pkg::SLC_TY_S;
   assign is_u = rx_valid && rx_ctrl[7:5] == slc_pkg::SLC_TY_U;
   assign is_reset = is_u && rx_ctrl[4:0] == slc_pkg::SLC_U_RESET;
   assign is_ack = is_u && rx_ctrl[4:0] == slc_pkg::SLC_U_ACK && rx_plen == 2'h0;
   assign r_ns = rx_ctrl[5:3];
   assign r_nr = rx_ctrl[2:0];
   assign r_kind = rx_ctrl[4:3];
   // Absent bytes take defaults; reserved capability bits ignored
   assign off_win = (rx_plen >= 2'h1 && rx_win >= 8'(slc_pkg::SLC_WIN_MIN)
                     && rx_win <= 8'(slc_pkg::SLC_WIN_DEF)) ?
                    rx_win[2:0] : slc_pkg::SLC_WIN_DEF;
   assign off_selective_reject_frame = (rx_plen == 2'h2) ? rx_cap[slc_pkg::SLC_CAP_SELECTIVE_REJECT_FRAME_BIT] : 1'b0;

   // ======================================
   // Link state
   // ======================================
   slc_state_t st_q;
   logic [2:0] win_q, pend_win_q;
   logic selective_reject_frame_q, pend_selective_reject_frame_q;
   logic [2:0] ns_q, nr_q, dn_q;
   logic conn_exp, ack_exp, retx_exp;
   logic establish;
   logic ans_reset, ans_ack;
   logic [2:0] my_win;
   logic my_selective_reject_frame;

   assign my_win = (LOCAL_WIN < off_win) ? LOCAL_WIN : off_win;
   assign my_selective_reject_frame = LOCAL_SELECTIVE_REJECT_FRAME & off_selective_reject_frame;
   // Too large window or unsupported capability: reset, else acknowledge
   assign ans_reset = is_reset && (my_win != off_win || my_selective_reject_frame != off_selective_reject_frame);
   assign ans_ack = is_reset && !ans_reset;
   // Established on acknowledge to our reset, or on acknowledging theirs
   assign establish = (st_q == SLC_WAIT && is_ack) || ans_ack;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_q <= SLC_DOWN;
      end else if (establish) begin
         st_q <= SLC_UP;
      end else if (link_start || conn_exp || ans_reset) begin
         st_q <= SLC_WAIT;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         win_q <= slc_pkg::SLC_WIN_DEF;
         selective_reject_frame_q <= 1'b0;
         pend_win_q <= LOCAL_WIN;
         pend_selective_reject_frame_q <= LOCAL_SELECTIVE_REJECT_FRAME;
      end else if (ans_ack) begin
         win_q <= off_win;
         selective_reject_frame_q <= off_selective_reject_frame;
      end else if (ans_reset) begin
         pend_win_q <= my_win;
         pend_selective_reject_frame_q <= my_selective_reject_frame;
      end else if (establish) begin
         win_q <= pend_win_q;
         selective_reject_frame_q <= pend_selective_reject_frame_q;
      end else if (link_start) begin
         pend_win_q <= LOCAL_WIN;
         pend_selective_reject_frame_q <= LOCAL_SELECTIVE_REJECT_FRAME;
      end
   end

   // ======================================
   // Sequence counters
   // ======================================
   logic up, i_ok, i_emit;
   logic [2:0] ack_nr;
   logic ack_valid, rej_rx;
   assign up = st_q == SLC_UP;
   assign i_ok = up && is_i && r_ns == nr_q;
   assign ack_nr = r_nr;
   assign ack_valid = up && (is_i || (is_s && r_kind != slc_pkg::SLC_S_SELECTIVE_REJECT_FRAME))
                      && (in_win(dn_q, ack_nr, ns_q) || ack_nr == ns_q);
   assign i_emit = tx_valid && tx_ready && tx_ctrl[7:6] == slc_pkg::SLC_TY_I0;
   assign rej_rx = up && is_s && r_kind == slc_pkg::SLC_S_REJ && ack_valid;

   always_ff @(posedge core_clk) begin
      if (!rst_n || establish) begin
         ns_q <= 3'h0;
      end else if (rej_rx) begin
         ns_q <= ack_nr; // Go back to first missing frame
      end else if (retx_exp) begin
         ns_q <= dn_q;
      end else if (i_emit) begin
         ns_q <= ns_q + 3'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || establish) begin
         nr_q <= 3'h0;
      end else if (i_ok) begin
         nr_q <= nr_q + 3'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || establish) begin
         dn_q <= 3'h0;
      end else if (ack_valid) begin
         dn_q <= ack_nr;
      end
   end

   // ======================================
   // Peer flow control and reject tracking
   // ======================================
   logic peer_busy_q, selective_reject_frame_out_q, rej_out_q, ack_due_q;
   logic [2:0] selective_reject_frame_seq_q;
   logic need_rej, need_selective_reject_frame, gap;
   assign gap = up && is_i && r_ns != nr_q;
   assign need_selective_reject_frame = gap && selective_reject_frame_q && r_ns == nr_q + 3'h1 && !selective_reject_frame_out_q;
   assign need_rej = gap && !need_selective_reject_frame && !rej_out_q && !selective_reject_frame_out_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n || establish) begin
         peer_busy_q <= 1'b0;
      end else if (up && is_s && r_kind == slc_pkg::SLC_S_RNR) begin
         peer_busy_q <= 1'b1;
      end else if (up && is_s && r_kind == slc_pkg::SLC_S_RR) begin
         peer_busy_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || establish) begin
         selective_reject_frame_out_q <= 1'b0;
         rej_out_q <= 1'b0;
      end else begin
         if (i_ok) begin
            selective_reject_frame_out_q <= 1'b0;
            rej_out_q <= 1'b0;
         end
         if (need_selective_reject_frame) begin
            selective_reject_frame_out_q <= 1'b1;
         end
         if (need_rej) begin
            rej_out_q <= 1'b1;
         end
      end
   end

   // ======================================
   // Transmit scheduling
   // ======================================
   // Pending requests, set wins over clear
   logic p_reset_q, p_ack_q, p_rej_q, p_selective_reject_frame_q, p_rr_q, retx_q;
   logic s_sent, u_sent, sent;
   logic [2:0] outstanding, retx_end_q, retx_top, retx_from;
   assign sent = tx_valid && tx_ready;
   assign outstanding = ns_q - dn_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         p_reset_q <= 1'b0;
         p_ack_q <= 1'b0;
      end else begin
         p_reset_q <= (p_reset_q && !(sent && tx_ctrl == mk_u(slc_pkg::SLC_U_RESET)))
                      || link_start || conn_exp || ans_reset;
         p_ack_q <= (p_ack_q && !(sent && tx_ctrl == mk_u(slc_pkg::SLC_U_ACK))) || ans_ack;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || establish) begin
         p_rej_q <= 1'b0;
         p_selective_reject_frame_q <= 1'b0;
         p_rr_q <= 1'b0;
         selective_reject_frame_seq_q <= 3'h0;
      end else begin
         p_rej_q <= (p_rej_q && !(sent && tx_ctrl[7:3] == {slc_pkg::SLC_TY_S,
                      slc_pkg::SLC_S_REJ})) || need_rej;
         p_selective_reject_frame_q <= (p_selective_reject_frame_q && !(sent && tx_ctrl[7:3] == {slc_pkg::SLC_TY_S,
                       slc_pkg::SLC_S_SELECTIVE_REJECT_FRAME})) || need_selective_reject_frame;
         if (need_selective_reject_frame) begin
            selective_reject_frame_seq_q <= nr_q;
         end
         p_rr_q <= (p_rr_q && !(sent && tx_ctrl[7:5] != slc_pkg::SLC_TY_U)) || ack_exp;
      end
   end

   // Resend from the rewind point up to the highest number already sent
   assign retx_top = retx_q ? retx_end_q : ns_q + {2'h0, i_emit};
   assign retx_from = rej_rx ? ack_nr : dn_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n || establish) begin
         retx_q <= 1'b0;
         retx_end_q <= 3'h0;
      end else if (retx_exp || rej_rx) begin
         retx_q <= retx_top != retx_from;
         retx_end_q <= retx_top;
      end else if (retx_q && i_emit && ns_q + 3'h1 == retx_end_q) begin
         retx_q <= 1'b0;
      end
   end

   always_comb begin
      tx_valid = 1'b0;
      tx_ctrl = 8'h00;
      tx_plen = 2'h0;
      tx_retx = 1'b0;
      info_gnt = 1'b0;
      if (p_reset_q) begin
         tx_valid = 1'b1;
         tx_ctrl = mk_u(slc_pkg::SLC_U_RESET);
         tx_plen = 2'h2;
      end else if (p_ack_q) begin
         tx_valid = 1'b1;
         tx_ctrl = mk_u(slc_pkg::SLC_U_ACK);
      end else if (up && p_selective_reject_frame_q && selective_reject_frame_q) begin
         tx_valid = 1'b1;
         tx_ctrl = mk_s(slc_pkg::SLC_S_SELECTIVE_REJECT_FRAME, selective_reject_frame_seq_q);
      end else if (up && p_rej_q) begin
         tx_valid = 1'b1;
         tx_ctrl = mk_s(slc_pkg::SLC_S_REJ, nr_q);
      end else if (up && !peer_busy_q && !local_busy && (info_req || retx_q)
                   && outstanding < win_q) begin
         tx_valid = 1'b1;
         tx_ctrl = {1'b1, 1'b0, ns_q, nr_q};
         tx_retx = retx_q;
         info_gnt = !retx_q && tx_ready;
      end else if (up && (p_rr_q || ack_due_q && local_busy)) begin
         tx_valid = 1'b1;
         tx_ctrl = mk_s(local_busy ? slc_pkg::SLC_S_RNR : slc_pkg::SLC_S_RR, nr_q);
      end
   end

   assign tx_retx_seq = ns_q;
   assign tx_win = {5'h0, pend_win_q};
   assign tx_cap = {7'h0, pend_selective_reject_frame_q};

   // ======================================
   // Timers
   // ======================================
   logic [31:0] ack_lim;
   assign ack_lim = (32'(ACK_CYC) * {29'h0, win_q}) >> 2;

   always_ff @(posedge core_clk) begin
      if (!rst_n || establish) begin
         ack_due_q <= 1'b0;
      end else if (i_ok) begin
         ack_due_q <= 1'b1;
      end else if (sent && tx_ctrl[7:5] != slc_pkg::SLC_TY_U) begin
         ack_due_q <= 1'b0;
      end
   end

   slc_timer u_ack_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(i_ok && !ack_due_q),
      .stop(establish || (sent && tx_ctrl[7:5] != slc_pkg::SLC_TY_U)),
      .limit(ack_lim),
      .expired(ack_exp)
   );

   slc_timer u_retransmit_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(i_emit),
      .stop(establish || (ack_valid && ack_nr == ns_q)),
      .limit(32'(RETX_CYC)),
      .expired(retx_exp)
   );

   slc_timer u_connect_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(sent && tx_ctrl == mk_u(slc_pkg::SLC_U_RESET)),
      .stop(establish || (st_q == SLC_WAIT && is_reset)),
      .limit(32'(CONN_CYC)),
      .expired(conn_exp)
   );

   // ======================================
   // Status
   // ======================================
   assign rx_deliver = i_ok && rx_has_info;
   assign link_up = up;
   assign win_size = win_q;
   assign selective_reject_frame_en = selective_reject_frame_q;
   assign send_seq = ns_q;
   assign recv_seq = nr_q;
   assign oldest_unacked_seq = dn_q;
   assign link_reset_evt = establish;
endmodule

// ---- test/slc_ctrl_asserts.sv ----
`timescale 1ns/1ps
// =====================================
// Link controller port checks
module slc_asserts (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_ctrl,
   input wire logic [1:0] tx_plen,
   input wire logic tx_retx,
   input wire logic info_gnt,
   input wire logic rx_deliver,
   input wire logic link_up,
   input wire logic [2:0] win_size,
   input wire logic selective_reject_frame_en,
   input wire logic [2:0] send_seq,
   input wire logic [2:0] recv_seq,
   input wire logic [2:0] oldest_unacked_seq,
   input wire logic link_reset_evt
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [2:0] outst;
   assign outst = send_seq - oldest_unacked_seq;
   AST_CTRL_MSB: assert property (tx_valid |-> tx_ctrl[7])
      else $error("control top bit clear");
   AST_S_NO_INFO: assert property (tx_valid && tx_ctrl[7:5] == 3'h6 |-> tx_plen == 2'h0)
      else $error("supervisory frame with payload");
   AST_U_CODE: assert property (tx_valid && tx_ctrl[7:5] == 3'h7 |->
      tx_ctrl[4:0] == 5'h19 || (tx_ctrl[4:0] == 5'h06 && tx_plen == 2'h0))
      else $error("bad unnumbered frame");
   AST_SELECTIVE_REJECT_FRAME_NEG: assert property (tx_valid && tx_ctrl[7:3] == 5'h1b |-> selective_reject_frame_en)
      else $error("selective reject not negotiated");
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_ctrl) && $stable(tx_plen))
      else $error("frame dropped before taken");
   AST_SEND_INC: assert property (tx_valid && tx_ready && tx_ctrl[7:6] == 2'h2 && !tx_retx |->
      tx_ctrl[5:3] == send_seq ##1 send_seq == $past(send_seq) + 3'h1)
      else $error("send number not advanced");
   AST_WINDOW: assert property (link_up |-> outst <= win_size)
      else $error("outstanding frames exceed window");
   AST_GNT_ROOM: assert property (info_gnt |-> outst < win_size)
      else $error("grant with full window");
   AST_EST_CLEAR: assert property (link_reset_evt |=> link_up && send_seq == 3'h0 &&
      recv_seq == 3'h0 && oldest_unacked_seq == 3'h0)
      else $error("counters not cleared");
   AST_WIN_RANGE: assert property (link_up |-> win_size >= 3'h2 && win_size <= 3'h4)
      else $error("window out of range");
   AST_WIN_FIXED: assert property (link_up && !link_reset_evt |=> $stable(win_size))
      else $error("window changed while up");
   AST_PRELINK: assert property (!link_up |-> !rx_deliver && !info_gnt)
      else $error("traffic before link up");
   AST_S_NR: assert property (tx_valid && tx_ctrl[7:5] == 3'h6 |-> tx_ctrl[2:0] == recv_seq)
      else $error("supervisory receive number wrong");
endmodule

bind slc_ctrl slc_asserts asserts_u (
   .core_clk(core_clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .tx_ctrl(tx_ctrl), .tx_plen(tx_plen), .tx_retx(tx_retx), .info_gnt(info_gnt),
   .rx_deliver(rx_deliver), .link_up(link_up), .win_size(win_size), .selective_reject_frame_en(selective_reject_frame_en),
   .send_seq(send_seq), .recv_seq(recv_seq), .oldest_unacked_seq(oldest_unacked_seq),
   .link_reset_evt(link_reset_evt)
);

// ---- test/slc_peer.sv ----
`timescale 1ns/1ps
// =====================================
// Peer endpoint taking frames
module slc_peer (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic selective_reject_frame_en,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_ctrl,
   input wire logic [1:0] tx_plen,
   input wire logic [7:0] tx_win,
   input wire logic [7:0] tx_cap,
   input wire logic tx_retx,
   output logic [26:0] last,
   output int frames,
   output int bad
);
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tx_ready <= 1'b0;
         frames <= 0;
         bad <= 0;
      end else begin
         tx_ready <= !stall;
         if (tx_valid && tx_ready) begin
            frames <= frames + 1;
            last <= {tx_retx, tx_plen, tx_win, tx_cap, tx_ctrl};
            if (!tx_ctrl[7] || (tx_ctrl[7:5] == 3'h6 && tx_plen != 2'h0)
                || (tx_ctrl[7:3] == 5'h1b && !selective_reject_frame_en)
                || (tx_ctrl[7:5] == 3'h7 && tx_ctrl[4:0] != 5'h19 && tx_ctrl[4:0] != 5'h06)) begin
               bad <= bad + 1;
            end
         end
      end
   end
endmodule

// ---- test/test_sliding_window_link_controller.sv ----
`timescale 1ns/1ps
// =====================================
// Link controller bench
module test_sliding_window_link_controller;
   localparam int ACK = 20;
   localparam int RETX = 60;
   localparam int CONN = 20;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic link_start = 1'b0;
   logic rx_valid = 1'b0;
   logic [7:0] rx_ctrl = 8'h00;
   logic [1:0] rx_plen = 2'h0;
   logic [7:0] rx_win = 8'h00;
   logic [7:0] rx_cap = 8'h00;
   logic rx_has_info = 1'b0;
   logic info_req = 1'b0;
   logic local_busy = 1'b0;
   logic stall = 1'b0;
   logic info_gnt, tx_valid, tx_ready, tx_retx, rx_deliver, link_up, selective_reject_frame_en, link_reset_evt;
   logic [7:0] tx_ctrl, tx_win, tx_cap;
   logic [1:0] tx_plen;
   logic [2:0] tx_retx_seq, win_size, send_seq, recv_seq, oldest_unacked_seq;
   logic [26:0] last;
   int frames, bad, mark;
   int num_errors = 0;
   int cmp_count = 0;
   int deliv = 0;
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (rx_deliver === 1'b1) begin
         deliv <= deliv + 1;
      end
   end
   slc_ctrl #(.ACK_CYC(ACK), .RETX_CYC(RETX), .CONN_CYC(CONN)) dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .link_start(link_start), .rx_valid(rx_valid),
      .rx_ctrl(rx_ctrl), .rx_plen(rx_plen), .rx_win(rx_win), .rx_cap(rx_cap),
      .rx_has_info(rx_has_info), .info_req(info_req), .info_gnt(info_gnt),
      .local_busy(local_busy), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_ctrl(tx_ctrl),
      .tx_plen(tx_plen), .tx_win(tx_win), .tx_cap(tx_cap), .tx_retx(tx_retx),
      .tx_retx_seq(tx_retx_seq), .rx_deliver(rx_deliver), .link_up(link_up),
      .win_size(win_size), .selective_reject_frame_en(selective_reject_frame_en), .send_seq(send_seq), .recv_seq(recv_seq),
      .oldest_unacked_seq(oldest_unacked_seq), .link_reset_evt(link_reset_evt)
   );
   slc_peer peer_u (
      .core_clk(core_clk), .rst_n(rst_n), .stall(stall), .selective_reject_frame_en(selective_reject_frame_en),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_ctrl(tx_ctrl), .tx_plen(tx_plen),
      .tx_win(tx_win), .tx_cap(tx_cap), .tx_retx(tx_retx), .last(last), .frames(frames),
      .bad(bad)
   );
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rx(input logic [7:0] c, input logic [1:0] pl, input logic [7:0] w,
                     input logic [7:0] cp, input logic inf);
      mark = frames;
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_ctrl <= c;
      rx_plen <= pl;
      rx_win <= w;
      rx_cap <= cp;
      rx_has_info <= inf;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_ctrl <= ~c;
      rx_win <= ~w;
      rx_cap <= ~cp;
   endtask
   // Waits for a new frame with the given control byte
   task automatic wait_tx(input logic [7:0] c, input int lim);
      for (int i = 0; i <= lim; i++) begin
         @(negedge core_clk);
         if (frames != mark && last[7:0] === c) begin
            chk("tx_ctrl", last[7:0], c);
            return;
         end
      end
      chk("tx_ctrl", last[7:0], c);
      num_errors++;
      wrap_up();
   endtask
   task automatic send_i(input logic [7:0] c);
      bit got = 1'b0;
      mark = frames;
      @(posedge core_clk);
      info_req <= 1'b1;
      repeat (20) begin
         @(negedge core_clk);
         if (info_gnt === 1'b1) begin
            got = 1'b1;
            break;
         end
      end
      @(posedge core_clk);
      info_req <= 1'b0;
      if (!got) begin
         num_errors++;
         wrap_up();
      end
      wait_tx(c, 10);
   endtask
   task automatic full();
      int g = 0;
      @(posedge core_clk);
      info_req <= 1'b1;
      repeat (6) begin
         @(negedge core_clk);
         if (info_gnt !== 1'b0) g++;
      end
      @(posedge core_clk);
      info_req <= 1'b0;
      chk("grants", 8'(g), 8'h00);
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      chk("link_up", 8'(link_up), 8'h00);
      chk("win_size", 8'(win_size), 8'h04);
      chk("send_seq", 8'(send_seq), 8'h00);
      rx(8'h80, 2'h0, 8'h00, 8'h00, 1'b1);
      @(negedge core_clk);
      chk("recv_seq", 8'(recv_seq), 8'h00);
      @(posedge core_clk);
      stall <= 1'b1;
      link_start <= 1'b1;
      mark = frames;
      @(posedge core_clk);
      link_start <= 1'b0;
      repeat (4) @(posedge core_clk);
      stall <= 1'b0;
      wait_tx(8'hf9, 8);
      chk("reset win", last[23:16], 8'h04);
      chk("reset cap", last[15:8], 8'h01);
      mark = frames;
      wait_tx(8'hf9, 3 * CONN);
      rx(8'he6, 2'h0, 8'h00, 8'h00, 1'b0);
      @(negedge core_clk);
      chk("link_up", 8'(link_up), 8'h01);
      chk("selective_reject_frame_en", 8'(selective_reject_frame_en), 8'h01);
      for (int i = 0; i < 4; i++) send_i(8'h80 | 8'(i << 3));
      full();
      rx(8'hc4, 2'h0, 8'h00, 8'h00, 1'b0);
      @(negedge core_clk);
      chk("oldest", 8'(oldest_unacked_seq), 8'h04);
      for (int i = 4; i < 8; i++) send_i(8'h80 | 8'(i << 3));
      chk("send_seq", 8'(send_seq), 8'h00);
      full();
      rx(8'hc0, 2'h0, 8'h00, 8'h00, 1'b0);
      @(negedge core_clk);
      chk("oldest", 8'(oldest_unacked_seq), 8'h00);
      send_i(8'h80);
      mark = frames;
      wait_tx(8'h80, 2 * RETX);
      chk("retx", 8'(last[26]), 8'h01);
      chk("retx_seq", 8'(tx_retx_seq), 8'h01);
      rx(8'hc1, 2'h0, 8'h00, 8'h00, 1'b0);
      rx(8'h81, 2'h0, 8'h00, 8'h00, 1'b1);
      @(negedge core_clk);
      chk("recv_seq", 8'(recv_seq), 8'h01);
      wait_tx(8'hc1, 3 * ACK);
      @(posedge core_clk);
      local_busy <= 1'b1;
      rx(8'h89, 2'h0, 8'h00, 8'h00, 1'b1);
      wait_tx(8'hd2, 3 * ACK);
      @(posedge core_clk);
      local_busy <= 1'b0;
      rx(8'h99, 2'h0, 8'h00, 8'h00, 1'b1);
      wait_tx(8'hda, 8);
      rx(8'h91, 2'h0, 8'h00, 8'h00, 1'b1);
      rx(8'hb1, 2'h0, 8'h00, 8'h00, 1'b1);
      wait_tx(8'hcb, 8);
      rx(8'hff, 2'h0, 8'h00, 8'h00, 1'b0);
      @(negedge core_clk);
      chk("link_up", 8'(link_up), 8'h01);
      chk("recv_seq", 8'(recv_seq), 8'h03);
      rx(8'hf9, 2'h2, 8'h02, 8'h00, 1'b0);
      wait_tx(8'he6, 8);
      chk("ack plen", 8'(last[25:24]), 8'h00);
      chk("win_size", 8'(win_size), 8'h02);
      chk("selective_reject_frame_en", 8'(selective_reject_frame_en), 8'h00);
      chk("send_seq", 8'(send_seq), 8'h00);
      send_i(8'h80);
      send_i(8'h88);
      full();
      chk("delivered", 8'(deliv), 8'h03);
      chk("bad frames", 8'(bad), 8'h00);
      wrap_up();
   end
endmodule
